// >>> dsr_far_end.sv
`timescale 1ns/1ps
// ----
// far side logic driving the device pins
// ----
module dsr_far_end
(
   // core clock
   input wire logic ref_clk,
   // device pins
   output logic shift_clk,
   output logic path_select,
   output logic data_in_a,
   output logic data_in_b
);
   // clock parks high: a low park would lose data on the real part
   initial
   begin
      shift_clk = 1'b1;
      path_select = 1'b0;
      data_in_a = 1'b0;
      data_in_b = 1'b0;
   end
   // one shift: inputs set at the start of the low phase; data pins change again five cycles after the rise
   task automatic pulse(input logic sel, input logic a, input logic b);
      @(negedge ref_clk);
      {shift_clk, path_select, data_in_a, data_in_b} = {1'b0, sel, a, b};
      repeat (4) @(negedge ref_clk);
      shift_clk = 1'b1;
      repeat (5) @(negedge ref_clk);
      {data_in_a, data_in_b} = {~a, ~b}; // stale data shown inverted
   endtask
endmodule // dsr_far_end

// >>> dsr_fifo.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// small flop fifo, valid/ready on both sides
// ------------------------------------------------------------
module dsr_fifo
   import dsr_pkg::*;
#(
   parameter int WIDTH = DSR_FIFO_WIDTH,
   parameter int DEPTH = DSR_FIFO_DEPTH
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   // pointer wrap logic only works for power-of-two depths
   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
   begin : g_bad_size
      $error("dsr_fifo: depth must be a power of two >= 2");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   // full when pointers differ only in the wrap bit
   assign in_ready = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
   assign out_valid = wr_q != rd_q;
   assign out_data = mem_q[rd_q[AW-1:0]];

   // pointers
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop) rd_q <= rd_q + 1'b1;
      end
   end

   // storage needs no reset
   always_ff @(posedge ref_clk)
   begin
      if (push) mem_q[wr_q[AW-1:0]] <= in_data;
   end
endmodule // dsr_fifo

// >>> dsr_pkg.sv
// ------------------------------------------------------------
// shared constants for the dual shift register
// ------------------------------------------------------------
package dsr_pkg;
   localparam int DSR_DEPTH = 128;
   localparam int DSR_SYNC_STAGES = 2;
   localparam int DSR_FIFO_WIDTH = 2;
   localparam int DSR_FIFO_DEPTH = 16;
   localparam logic [1:0] DSR_SEL_EXT = 2'h0;
   localparam logic [1:0] DSR_SEL_RECIRC = 2'h1;
endpackage

// >>> dsr_shift.sv
`timescale 1ns/1ps
// What this block does
// - two 128-bit registers, each with input mux
// - one shared clock advances both registers
// - shift one place on rising edge only
// - select low loads external serial data
// - select high loads recirculation input
// - contents hold while clock stays high
// - last stage drives separate serial output
module dsr_shift
   import dsr_pkg::*;
#(
   parameter int DEPTH = DSR_DEPTH
)
(
   // core clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // device pins, asynchronous to ref_clk
   input wire logic shift_clk,
   input wire logic path_select,
   input wire logic data_in_a,
   input wire logic data_in_b,
   input wire logic recirc_in_a,
   input wire logic recirc_in_b,
   // serial outputs
   output logic data_out_a,
   output logic data_out_b,
   // buffered output stream, one word per shift
   output logic stream_valid,
   input wire logic stream_ready,
   output logic [1:0] stream_data,
   output logic overflow
);
   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   // the chain slicing needs two stages at least
   if (DEPTH < 2)
   begin : g_bad_depth
      $error("dsr_shift: depth must be at least 2");
   end
   // the stream word is one bit per register, and the edge logic
   // below is written for exactly two synchroniser stages
   if (DSR_FIFO_WIDTH != 2 || DSR_SYNC_STAGES != 2)
   begin : g_bad_pkg
      $error("dsr_shift: package widths do not match the stream port");
   end

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   // all six pins pass two flops before any logic reads them; the
   // clock pin shares the flops with the data pins, so both see the
   // same sample and a shift never mixes old and new data
   logic [5:0] pin_s1_q;
   logic [5:0] pin_s2_q;
   logic clk_prev_q;
   always_ff @(posedge ref_clk)
   begin
      pin_s1_q <= {shift_clk, path_select, data_in_a, data_in_b, recirc_in_a, recirc_in_b};
      pin_s2_q <= pin_s1_q;
   end
   wire clk_s = pin_s2_q[5];
   wire sel_s = pin_s2_q[4];
   wire din_a_s = pin_s2_q[3];
   wire din_b_s = pin_s2_q[2];
   wire rin_a_s = pin_s2_q[1];
   wire rin_b_s = pin_s2_q[0];

   // history is reset high: a pin clock parked high across reset
   // must not count as a rising edge when reset lifts
   // edge history only; reset gives a known start so no false edge
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n) clk_prev_q <= 1'b1;
      else clk_prev_q <= clk_s;
   end
   // both registers use this one enable, so they cannot drift apart
   // rising edge of the shared clock, a one-cycle enable
   wire shift_en = clk_s && !clk_prev_q;

   // ------------------------------------------------------------
   // input multiplexers and shift chains
   // ------------------------------------------------------------
   // inputs were sampled with the clock pin in the same flop, so the
   // data taken is the data present at the edge, as the driver
   // keeps it stable around that edge
   // source choice for one register; both registers share the one select
   function automatic logic dsr_pick(input logic sel, input logic rin, input logic din);
      logic pick;
      pick = din;
      if ({1'b0, sel} == DSR_SEL_RECIRC)
         pick = rin;
      return pick;
   endfunction
   wire bit_a = dsr_pick(sel_s, rin_a_s, din_a_s);
   wire bit_b = dsr_pick(sel_s, rin_b_s, din_b_s);

   logic [DEPTH-1:0] chain_a_q;
   logic [DEPTH-1:0] chain_b_q;
   // trade-off: skipping reset keeps the chains plain flops, but a
   // known output needs a full 128 shifts after power-up
   // no reset on the chains: storage starts undefined
   always_ff @(posedge ref_clk)
   begin
      if (shift_en)
      begin
         chain_a_q <= {chain_a_q[DEPTH-2:0], bit_a};
         chain_b_q <= {chain_b_q[DEPTH-2:0], bit_b};
      end
   end
   // the serial outputs are the last flops themselves, no extra stage
   // output changes one core cycle after the edge, past the hold window
   assign data_out_a = chain_a_q[DEPTH-1];
   assign data_out_b = chain_b_q[DEPTH-1];

   // ------------------------------------------------------------
   // output stream buffer
   // ------------------------------------------------------------
   // a word is queued per shift; a full buffer cannot stall the
   // pins, so the loss is flagged instead
   // limitation: the flag is sticky and only reset clears it, so a
   // consumer that stalled must be followed by a reset
   logic push_q;
   logic ovf_q;
   wire fifo_ready;
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         push_q <= 1'b0;
         ovf_q <= 1'b0;
      end
      else
      begin
         push_q <= shift_en;
         if (push_q && !fifo_ready) ovf_q <= 1'b1;
      end
   end
   assign overflow = ovf_q;

   // sixteen words cover a consumer that pauses for many shifts
   dsr_fifo #(.WIDTH(DSR_FIFO_WIDTH), .DEPTH(DSR_FIFO_DEPTH)) u_fifo
   (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .in_valid(push_q),
      .in_ready(fifo_ready),
      .in_data({data_out_b, data_out_a}),
      .out_valid(stream_valid),
      .out_ready(stream_ready),
      .out_data(stream_data)
   );

   // ------------------------------------------------------------
   // chain checks
   // ------------------------------------------------------------
   // the chains hold unknowns until they are filled, so the chain
   // compares use case equality: an unknown stage must stay unknown
   a_hold_no_edge: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !shift_en |=> chain_a_q === $past(chain_a_q) && chain_b_q === $past(chain_b_q))
      else $error("chain changed without a clock edge");
   a_rise_only: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $changed(chain_a_q[0]) |-> $past(shift_en))
      else $error("shift on a non-rising transition");
   a_sel_ext_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      shift_en && !sel_s |=> chain_a_q[0] === $past(din_a_s))
      else $error("register a did not take external data");
   a_sel_ext_b: assert property (@(posedge ref_clk) disable iff (!reset_n)
      shift_en && !sel_s |=> chain_b_q[0] === $past(din_b_s))
      else $error("register b did not take external data");
   a_sel_recirc_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      shift_en && sel_s |=> chain_a_q[0] === $past(rin_a_s))
      else $error("register a did not take recirculation data");
   a_sel_recirc_b: assert property (@(posedge ref_clk) disable iff (!reset_n)
      shift_en && sel_s |=> chain_b_q[0] === $past(rin_b_s))
      else $error("register b did not take recirculation data");
   a_both_shift: assert property (@(posedge ref_clk) disable iff (!reset_n)
      shift_en |=> chain_a_q[DEPTH-1:1] === $past(chain_a_q[DEPTH-2:0])
         && chain_b_q[DEPTH-1:1] === $past(chain_b_q[DEPTH-2:0]))
      else $error("registers did not shift together");
   a_tail_out: assert property (@(posedge ref_clk) disable iff (!reset_n)
      shift_en |=> data_out_a === $past(chain_a_q[DEPTH-2])
         && data_out_b === $past(chain_b_q[DEPTH-2]))
      else $error("serial output is not the bit from the last but one stage");

   // ------------------------------------------------------------
   // output and stream checks
   // ------------------------------------------------------------
   a_out_last: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $changed(data_out_a) |-> $past(shift_en))
      else $error("output changed without a shift");
   a_out_b_last: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $changed(data_out_b) |-> $past(shift_en))
      else $error("output b changed without a shift");
   a_one_edge: assert property (@(posedge ref_clk) disable iff (!reset_n)
      shift_en |=> !shift_en)
      else $error("edge enable longer than one cycle");
   a_push_follows: assert property (@(posedge ref_clk) disable iff (!reset_n)
      shift_en |=> push_q)
      else $error("shift word not queued");
   a_no_push_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !shift_en |=> !push_q)
      else $error("word queued without a shift");
   a_valid_after_push: assert property (@(posedge ref_clk) disable iff (!reset_n)
      push_q && fifo_ready |=> stream_valid)
      else $error("queued word not offered");
   a_ovf_on_drop: assert property (@(posedge ref_clk) disable iff (!reset_n)
      push_q && !fifo_ready |=> overflow)
      else $error("dropped word not flagged");
   a_ovf_sticky: assert property (@(posedge ref_clk) disable iff (!reset_n)
      overflow |=> overflow)
      else $error("overflow flag cleared without reset");

   c_shift_ext: cover property (@(posedge ref_clk) shift_en && !sel_s);
   c_shift_recirc: cover property (@(posedge ref_clk) shift_en && sel_s);
   c_fifo_full: cover property (@(posedge ref_clk) !fifo_ready);
   c_overflow: cover property (@(posedge ref_clk) $rose(ovf_q));
   c_back_to_back: cover property (@(posedge ref_clk) shift_en ##[6:12] shift_en);
endmodule // dsr_shift

// >>> tb_dsr_shift.sv
`timescale 1ns/1ps
module tb_dsr_shift;
   import dsr_pkg::*;
   typedef struct packed {logic sel; logic [127:0] pat; logic [127:0] exp;} dsr_row_t;
   logic ref_clk, reset_n, stream_ready, shift_clk, path_select, din_a, din_b;
   logic dout_a, dout_b, stream_valid, overflow;
   logic [1:0] stream_data;
   logic [127:0] seen_a, seen_b;
   int err_total, checks_done;
   // exp is the output stream of the row, bit i seen after shift i
   dsr_row_t rows [4] = '{'{1'b0, {32{4'h5}}, '0}, '{1'b0, {32{4'h3}}, {32{4'hA}}},
      '{1'b1, {32{4'h6}}, {32{4'h9}}}, '{1'b0, '0, {4'h1, {31{4'h9}}}}};
   // ----
   // clock, parts and helpers
   // ----
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   dsr_far_end far (.ref_clk(ref_clk), .shift_clk(shift_clk), .path_select(path_select),
      .data_in_a(din_a), .data_in_b(din_b));
   // outputs wired back for circulating storage
   dsr_shift dut (.ref_clk(ref_clk), .reset_n(reset_n), .shift_clk(shift_clk),
      .path_select(path_select), .data_in_a(din_a), .data_in_b(din_b),
      .recirc_in_a(dout_a), .recirc_in_b(dout_b), .data_out_a(dout_a),
      .data_out_b(dout_b), .stream_valid(stream_valid), .stream_ready(stream_ready),
      .stream_data(stream_data), .overflow(overflow));
   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      if (err_total == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // watchdog, far above the about 5630 cycles the run needs
   initial
   begin
      #160_000;
      err_total++;
      print_verdict();
   end
   initial
   begin
      reset_n = 1'b0;
      stream_ready = 1'b1;
      err_total = 0;
      checks_done = 0;
      repeat (20) @(negedge ref_clk);
      chk(stream_valid, 1'b0);
      chk(overflow, 1'b0);
      reset_n = 1'b1;
      // load, recirculate and reload; chain b gets the inverse of chain a
      foreach (rows[r])
      begin
         for (int i = 0; i < 128; i++)
         begin
            far.pulse(rows[r].sel, rows[r].pat[i], ~rows[r].pat[i]);
            seen_a[i] = dout_a;
            seen_b[i] = dout_b;
         end
         if (r > 0)
         begin
            chk(seen_a, rows[r].exp);
            chk(seen_b, ~rows[r].exp);
         end
      end
      // clock parked high for a long time: outputs must not move
      repeat (300) @(negedge ref_clk);
      chk({dout_b, dout_a}, 2'h2);
      // stall the consumer one word past the fifo depth, then drain
      stream_ready = 1'b0;
      repeat (DSR_FIFO_DEPTH + 1) far.pulse(1'b1, 1'b1, 1'b0);
      chk(overflow, 1'b1);
      stream_ready = 1'b1;
      for (int i = 0; i < DSR_FIFO_DEPTH; i++)
      begin
         chk(stream_valid, 1'b1);
         chk(stream_data, 2'h2);
         @(negedge ref_clk);
      end
      chk(stream_valid, 1'b0);
      // second reset clears the sticky flag
      reset_n = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk(overflow, 1'b0);
      print_verdict();
   end
endmodule // tb_dsr_shift
